/* File: design/slot_fifo_pkg.sv */
// constants for the slot fifo format selection block
package slot_fifo_pkg;
    // register addresses
    localparam logic [7:0]  ADDR_SLOT_CTRL     = 8'h11;
    localparam logic [7:0]  ADDR_AVG_FACTOR    = 8'h15;
    localparam logic [15:0] SLOT_CTRL_RESET    = 16'h1000;
    localparam logic [15:0] AVG_FACTOR_RESET   = 16'h0000;
    localparam logic [15:0] RD_UNMAPPED        = 16'h0000;
    // field positions in the slot control register
    localparam int          FIRST_EN_BIT       = 0;
    localparam int          FIRST_FMT_LSB      = 2;
    localparam int          SECOND_EN_BIT      = 5;
    localparam int          SECOND_FMT_LSB     = 6;
    localparam int          FMT_W              = 3;
    // field positions in the averaging register
    localparam int          FIRST_AVG_LSB      = 8;
    localparam int          SECOND_AVG_LSB     = 4;
    localparam int          AVG_W              = 3;
    // store format codes
    localparam logic [2:0]  FMT_NONE           = 3'h0;
    localparam logic [2:0]  FMT_SUM16          = 3'h1;
    localparam logic [2:0]  FMT_SUM32          = 3'h2;
    localparam logic [2:0]  FMT_CH16           = 3'h4;
    localparam logic [2:0]  FMT_CH32           = 3'h6;
    // fifo words produced by each format
    localparam logic [3:0]  WORDS_SUM16        = 4'h1;
    localparam logic [3:0]  WORDS_SUM32        = 4'h2;
    localparam logic [3:0]  WORDS_CH16         = 4'h4;
    localparam logic [3:0]  WORDS_CH32         = 4'h8;
    // data path shape
    localparam int          NUM_CH             = 4;
    localparam int          CH_W               = 32;
    localparam int          WORD_W             = 16;
    localparam int          FIFO_DEPTH         = 4;
    localparam int          STAGE_W            = 128;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_PUSH = 1'b1
    } seq_state_e;
endpackage : slot_fifo_pkg

/* File: design/slot_word_fifo.sv */
// small word fifo with registered read data
`timescale 1ns/10ps
module slot_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,       // system clock
    input  wire logic             rst,       // async reset, active high
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] in_data,   // write word
    output logic                  out_valid, // read word present
    input  wire logic             out_ready, // reader takes word
    output logic      [WIDTH-1:0] out_data   // read word, registered
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_MAX = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    logic             out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != CNT_MAX);
    assign push      = in_valid && in_ready;
    assign pop       = (count_reg != '0) && (!out_valid_reg || out_ready);
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + CNT_ONE;
            end else if (pop && !push) begin
                count_reg <= count_reg - CNT_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // output register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else if (pop) begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= mem[rd_ptr_reg];
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end
endmodule : slot_word_fifo

/* File: design/slot_fifo_format_select.sv */
// per-slot fifo store format selection with its control registers
//
// Summary of operation
// - Second slot format field at bits 8:6; zero stores nothing; 3, 5, 7 reserved.
// - Second slot code 1 writes 16-bit four-channel sum; code 2 a 32-bit sum.
// - Second slot code 4 writes four 16-bit channel words.
// - Second slot code 6 writes four 32-bit extended channel words.
// - Second slot stores only if averaging factors match or first slot format is zero.
// - Second slot enable at bit 5; one enables the second slot.
// - First slot format at bits 4:2; zero stores nothing, one a 16-bit sum.
// - First slot code 2 is 32-bit sum, 4 four 16-bit, 6 four 32-bit.
// - First slot enable at bit 0; one enables the first slot.
`timescale 1ns/10ps
module slot_fifo_format_select
    import slot_fifo_pkg::*;
(
    input  wire logic                  clk,                // system clock, 20 MHz
    input  wire logic                  rst,                // async reset, active high
    input  wire logic [7:0]            reg_addr,           // register address
    input  wire logic                  reg_wr_en,          // register write strobe
    input  wire logic [15:0]           reg_wr_data,        // register write data
    input  wire logic                  reg_rd_en,          // register read strobe
    output logic      [15:0]           reg_rd_data,        // register read data
    input  wire logic                  sample_valid,       // slot result offered
    input  wire logic                  sample_slot,        // 0 first slot, 1 second slot
    input  wire logic [STAGE_W-1:0]    sample_data,        // channel 0 in top 32 bits
    output logic                       sample_ready,       // result taken when high
    output logic                       first_slot_enable,  // first slot measures
    output logic                       second_slot_enable, // second slot measures
    output logic                       fifo_valid,         // fifo word present
    input  wire logic                  fifo_ready,         // reader takes fifo word
    output logic      [WORD_W-1:0]     fifo_data           // fifo word
);
    logic [15:0]        ctrl_reg;
    logic [15:0]        avg_reg;
    logic [15:0]        rd_data_reg;
    seq_state_e         state_reg;
    logic [STAGE_W-1:0] stage_reg;
    logic [3:0]         left_reg;
    logic               ready_reg;

    logic [FMT_W-1:0]   first_fmt;
    logic [FMT_W-1:0]   second_fmt;
    logic               second_allowed;
    logic [FMT_W-1:0]   sel_fmt;
    logic               sel_en;
    localparam int         PACK_W   = NUM_CH * WORD_W;
    localparam logic [3:0] LEFT_ONE = 4'h1;

    logic [CH_W-1:0]    ch    [NUM_CH];
    logic [WORD_W-1:0]  ch_lo [NUM_CH];
    logic [CH_W-1:0]    acc32 [NUM_CH+1];
    logic [WORD_W-1:0]  acc16 [NUM_CH+1];
    logic [PACK_W-1:0]  lo_pack;
    logic [CH_W-1:0]    sum32;
    logic [WORD_W-1:0]  sum16;
    logic [STAGE_W-1:0] stage_next;
    logic [3:0]         left_next;
    logic               fifo_in_ready;
    logic               push;
    logic               take;
    logic               start;
    logic               advance;
    logic               last_word;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    assign first_fmt          = ctrl_reg[FIRST_FMT_LSB +: FMT_W];
    assign second_fmt         = ctrl_reg[SECOND_FMT_LSB +: FMT_W];
    assign first_slot_enable  = ctrl_reg[FIRST_EN_BIT];
    assign second_slot_enable = ctrl_reg[SECOND_EN_BIT];
    assign reg_rd_data        = rd_data_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= SLOT_CTRL_RESET;
            avg_reg  <= AVG_FACTOR_RESET;
        end else if (reg_wr_en) begin
            if (reg_addr == ADDR_SLOT_CTRL) begin
                ctrl_reg <= reg_wr_data;
            end
            if (reg_addr == ADDR_AVG_FACTOR) begin
                avg_reg <= reg_wr_data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= RD_UNMAPPED;
        end else if (reg_rd_en) begin
            case (reg_addr)
                ADDR_SLOT_CTRL:  rd_data_reg <= ctrl_reg;
                ADDR_AVG_FACTOR: rd_data_reg <= avg_reg;
                default:         rd_data_reg <= RD_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // format selection
    // ------------------------------------------------------------
    // second slot may only share the fifo when the sample rates line up or the first slot format is zero
    assign second_allowed = (avg_reg[FIRST_AVG_LSB +: AVG_W]
                             == avg_reg[SECOND_AVG_LSB +: AVG_W])
                            || (first_fmt == FMT_NONE);
    assign sel_fmt = sample_slot ? second_fmt : first_fmt;
    assign sel_en  = sample_slot ? (second_slot_enable && second_allowed)
                                 : first_slot_enable;

    // running sums wrap at their own width, as the stored words do
    assign acc32[0] = '0;
    assign acc16[0] = '0;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign ch[i]      = sample_data[STAGE_W-1-i*CH_W -: CH_W];
        assign ch_lo[i]   = ch[i][WORD_W-1:0];
        assign acc32[i+1] = acc32[i] + ch[i];
        assign acc16[i+1] = acc16[i] + ch_lo[i];
        assign lo_pack[PACK_W-1-i*WORD_W -: WORD_W] = ch_lo[i];
    end

    assign sum32 = acc32[NUM_CH];
    assign sum16 = acc16[NUM_CH];

    always_comb begin
        stage_next = '0;
        left_next  = '0;
        if (sel_en) begin
            case (sel_fmt)
                FMT_SUM16: begin
                    stage_next = {sum16, {(STAGE_W-WORD_W){1'b0}}};
                    left_next  = WORDS_SUM16;
                end
                FMT_SUM32: begin
                    stage_next = {sum32, {(STAGE_W-CH_W){1'b0}}};
                    left_next  = WORDS_SUM32;
                end
                FMT_CH16: begin
                    stage_next = {lo_pack, {(STAGE_W-PACK_W){1'b0}}};
                    left_next  = WORDS_CH16;
                end
                FMT_CH32: begin
                    stage_next = sample_data;
                    left_next  = WORDS_CH32;
                end
                default: begin
                    stage_next = '0;
                    left_next  = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // word sequencer
    // ------------------------------------------------------------
    assign sample_ready = ready_reg;
    assign take         = sample_valid && ready_reg;
    assign push         = (state_reg == ST_PUSH);
    assign start        = take && (left_next != '0) && (state_reg == ST_IDLE);
    assign advance      = push && fifo_in_ready;
    assign last_word    = advance && (left_reg == LEFT_ONE);

    // sequencer state and the handshake back to the sample engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_PUSH;
                        ready_reg <= 1'b0;
                    end else begin
                        ready_reg <= 1'b1;
                    end
                end
                ST_PUSH: begin
                    if (last_word) begin
                        state_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // staged words leave from the top, one per push the fifo accepts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_reg <= '0;
            left_reg  <= '0;
        end else if (start) begin
            stage_reg <= stage_next;
            left_reg  <= left_next;
        end else if (advance) begin
            stage_reg <= {stage_reg[STAGE_W-WORD_W-1:0], {WORD_W{1'b0}}};
            left_reg  <= left_reg - LEFT_ONE;
        end
    end

    // ------------------------------------------------------------
    // sample fifo
    // ------------------------------------------------------------
    // a full fifo holds the sequencer in push, so no word is ever dropped
    slot_word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (stage_reg[STAGE_W-1 -: WORD_W]),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );
endmodule : slot_fifo_format_select

/* File: dv/slot_fifo_format_select_props.sv */
// assertion checker for the slot fifo format selection block
`timescale 1ns/10ps
module slot_fifo_format_select_props
    import slot_fifo_pkg::*;
(
    input wire logic              clk,                // clock
    input wire logic              rst,                // reset
    input wire logic [7:0]        reg_addr,           // address
    input wire logic              reg_wr_en,          // write
    input wire logic [15:0]       reg_wr_data,        // wdata
    input wire logic              reg_rd_en,          // read
    input wire logic [15:0]       reg_rd_data,        // rdata
    input wire logic              sample_valid,       // offer
    input wire logic              sample_slot,        // slot
    input wire logic              sample_ready,       // taken
    input wire logic              first_slot_enable,  // en a
    input wire logic              second_slot_enable, // en b
    input wire logic              fifo_valid,         // out valid
    input wire logic              fifo_ready,         // out ready
    input wire logic [WORD_W-1:0] fifo_data           // out word
);
    logic [15:0] ctrl_reg;
    logic [15:0] avg_reg;
    logic [2:0]  fmt;
    logic        stores;
    logic        taken;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) ctrl_reg <= SLOT_CTRL_RESET;
        else if (reg_wr_en && reg_addr == ADDR_SLOT_CTRL) ctrl_reg <= reg_wr_data;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) avg_reg <= AVG_FACTOR_RESET;
        else if (reg_wr_en && reg_addr == ADDR_AVG_FACTOR) avg_reg <= reg_wr_data;
    end
    assign fmt = sample_slot ? ctrl_reg[8:6] : ctrl_reg[4:2];
    assign taken = sample_valid && sample_ready;
    assign stores = (sample_slot ? ctrl_reg[5] : ctrl_reg[0])
        && fmt inside {FMT_SUM16, FMT_SUM32, FMT_CH16, FMT_CH32}
        && (!sample_slot || avg_reg[10:8] == avg_reg[6:4] || ctrl_reg[4:2] == FMT_NONE);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_first_enable: assert property (
        reg_wr_en && reg_addr == ADDR_SLOT_CTRL |=> first_slot_enable == $past(reg_wr_data[0]))
        else $error("first slot enable wrong");
    a_second_enable: assert property (
        reg_wr_en && reg_addr == ADDR_SLOT_CTRL |=> second_slot_enable == $past(reg_wr_data[5]))
        else $error("second slot enable wrong");
    a_ctrl_readback: assert property (
        reg_rd_en && reg_addr == ADDR_SLOT_CTRL |=> reg_rd_data == $past(ctrl_reg))
        else $error("control readback wrong");
    a_none_skips: assert property (
        taken && fmt == FMT_NONE |=> sample_ready)
        else $error("empty format stalled");
    a_gate_skips: assert property (
        taken && sample_slot && avg_reg[10:8] != avg_reg[6:4] && ctrl_reg[4:2] != FMT_NONE
        |=> sample_ready) else $error("gated slot stalled");
    a_store_stalls: assert property (
        taken && stores |=> !sample_ready) else $error("storing slot not stalled");
    a_store_ends: assert property (
        taken && stores |=> !sample_ready ##[1:200] sample_ready) else $error("store hung");
    a_fifo_holds: assert property (
        fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data))
        else $error("fifo word dropped");
endmodule : slot_fifo_format_select_props
bind slot_fifo_format_select slot_fifo_format_select_props i_props (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .sample_valid(sample_valid),
    .sample_slot(sample_slot), .sample_ready(sample_ready), .fifo_data(fifo_data),
    .first_slot_enable(first_slot_enable), .second_slot_enable(second_slot_enable),
    .fifo_valid(fifo_valid), .fifo_ready(fifo_ready));

/* File: dv/slot_host_model.sv */
// host model that programs the block's registers
`timescale 1ns/10ps
module slot_host_model (
    input  wire logic        clk,         // clock
    output logic      [7:0]  reg_addr,    // address
    output logic             reg_wr_en,   // write strobe
    output logic      [15:0] reg_wr_data, // write data
    output logic             reg_rd_en,   // read strobe
    input  wire logic [15:0] reg_rd_data  // read data
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'h0;
        reg_wr_data = 16'h0000;
        reg_rd_en = 1'h0;
    end
    // caller sits just after a rising edge
    task automatic write_reg(logic [7:0] addr, logic [15:0] data);
        reg_addr = addr;
        reg_wr_data = data;
        reg_wr_en = 1'h1;
        @(posedge clk) #2;
        reg_wr_en = 1'h0;
        reg_wr_data = ~data;
        @(posedge clk) #2;
    endtask : write_reg
    task automatic read_reg(logic [7:0] addr, output logic [15:0] data);
        reg_addr = addr;
        reg_rd_en = 1'h1;
        @(posedge clk) #2;
        reg_rd_en = 1'h0;
        data = reg_rd_data;
        @(posedge clk) #2;
    endtask : read_reg
endmodule : slot_host_model

/* File: dv/slot_fifo_format_select_tb_top.sv */
// self-checking bench for the slot fifo format selection block
`timescale 1ns/10ps
module slot_fifo_format_select_tb_top;
    import slot_fifo_pkg::*;
    localparam logic [127:0] SMP = 128'h1234_8001_A0B0_C0D0_0F0F_F0F0_FFFF_0002;
    logic clk = 0, rst = 1, reg_wr_en, reg_rd_en, sample_valid = 0, sample_slot = 0;
    logic sample_ready, first_slot_enable, second_slot_enable, fifo_valid, fifo_ready = 0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data, fifo_data, rd;
    logic [15:0] exp_q[$];
    int err_total = 0, check_count = 0, cycles = 0;
    logic [2:0] codes[4] = '{FMT_SUM16, FMT_SUM32, FMT_CH16, FMT_CH32};
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            finish_test();
        end
    end
    slot_host_model i_slot_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));
    slot_fifo_format_select i_slot_fifo_format_select (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .sample_valid(sample_valid),
        .sample_slot(sample_slot), .sample_data(SMP), .sample_ready(sample_ready),
        .first_slot_enable(first_slot_enable), .second_slot_enable(second_slot_enable),
        .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_data(fifo_data));
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // words the fifo should yield for one result; 32-bit values high half first
    function automatic void expect_words(logic [2:0] code);
        logic [31:0] s;
        s = 0;
        for (int c = 0; c < NUM_CH; c++) s += SMP[127-32*c -: 32];
        if (code == FMT_SUM32) exp_q.push_back(s[31:16]);
        if (code inside {FMT_SUM16, FMT_SUM32}) exp_q.push_back(s[15:0]);
        for (int c = 0; c < NUM_CH; c++) begin
            if (code == FMT_CH32) exp_q.push_back(SMP[127-32*c -: 16]);
            if (code inside {FMT_CH16, FMT_CH32}) exp_q.push_back(SMP[111-32*c -: 16]);
        end
    endfunction : expect_words
    task automatic run(string name, logic slot, logic [15:0] ctrl, logic [15:0] avg,
                       logic [2:0] code);
        i_slot_host_model.write_reg(ADDR_SLOT_CTRL, ctrl);
        i_slot_host_model.write_reg(ADDR_AVG_FACTOR, avg);
        expect_words(code);
        sample_slot = slot;
        sample_valid = 1'h1;
        while (sample_ready !== 1'h1) @(posedge clk) #2;
        @(posedge clk) #2;
        sample_valid = 1'h0;
        check("sample_ready", sample_ready, exp_q.size() == 0);
        // the 32-bit channel format overfills the fifo while the reader stalls
        repeat (code == FMT_CH32 ? 20 : 0) @(posedge clk) #2;
        fifo_ready = 1'h1;
        while (exp_q.size() > 0) begin
            if (fifo_valid === 1'h1) check("fifo_data", fifo_data, exp_q.pop_front());
            @(posedge clk) #2;
        end
        fifo_ready = 1'h0;
        repeat (12) @(posedge clk) #2;
        check("fifo_valid", fifo_valid, 0);
        $display("test %s done", name);
    endtask : run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (4) @(posedge clk);
        #2 rst = 0;
        @(posedge clk) #2;
        i_slot_host_model.read_reg(ADDR_SLOT_CTRL, rd);
        check("ctrl reset", rd, SLOT_CTRL_RESET);
        i_slot_host_model.read_reg(8'h12, rd);
        check("unmapped", rd, RD_UNMAPPED);
        i_slot_host_model.write_reg(ADDR_SLOT_CTRL, 16'h0001);
        check("enables", {first_slot_enable, second_slot_enable}, 2'h2);
        i_slot_host_model.write_reg(ADDR_SLOT_CTRL, 16'h1020);
        check("enables", {first_slot_enable, second_slot_enable}, 2'h1);
        i_slot_host_model.read_reg(ADDR_SLOT_CTRL, rd);
        check("ctrl readback", rd, 16'h1020);
        i_slot_host_model.write_reg(ADDR_AVG_FACTOR, 16'h0560);
        i_slot_host_model.read_reg(ADDR_AVG_FACTOR, rd);
        check("avg readback", rd, 16'h0560);
        foreach (codes[i]) begin
            run("first fmt", 0, 16'h1001 | (codes[i] << 2), 0, codes[i]);
            run("second fmt", 1, 16'h1020 | (codes[i] << 6), 0, codes[i]);
        end
        run("first none", 0, 16'h1001, 0, FMT_NONE);
        run("reserved", 1, 16'h10E0, 0, FMT_NONE);
        run("disabled", 1, 16'h1040, 0, FMT_NONE);
        run("gated", 1, 16'h1065, 16'h0100, FMT_NONE);
        run("matched", 1, 16'h1065, 16'h0110, FMT_SUM16);
        run("first idle", 1, 16'h1061, 16'h0100, FMT_SUM16);
        finish_test();
    end
endmodule : slot_fifo_format_select_tb_top
